/* core/pcdt_pkg.sv */
// Purpose: Shared constants and types for the clock divider tree.
// Assumes: All clock activity is modelled as edge events on core_clk.
// Notes:   Ratios of zero are treated as a ratio of one.
`default_nettype none
package pcdt_pkg;
  localparam int unsigned PCDT_CTRLS        = 2;
  localparam int unsigned PCDT_PRIM_DOMAINS = 9;
  localparam int unsigned PCDT_SEC_DOMAINS  = 5;
  localparam int unsigned PCDT_RATIO_W      = 5;
  localparam int unsigned PCDT_MULT_W       = 8;
  localparam int unsigned PCDT_PERIOD_W     = 16;
  localparam int unsigned PCDT_ACC_W        = 17;
  localparam logic [4:0]  PCDT_RATIO_RST    = 5'h01;
  localparam logic        PCDT_MODE_RST     = 1'b0;
  localparam logic [15:0] PCDT_PERIOD_MAX   = 16'hFFFF;
  // Reference cycles software waits after leaving multiplied mode.
  localparam int unsigned PCDT_BYPASS_SETTLE_REF_CYCLES = 4;
  typedef enum logic {PCDT_GO_IDLE, PCDT_GO_HALT} pcdt_go_e;
endpackage
`default_nettype wire

/* core/pcdt_divider.sv */
// Purpose: One edge-counting divider with a 50% duty output level.
// Assumes: src_edge pulses once per edge (two per period) of its source.
// Notes:   Halt freezes the output once it is low; restart forces a rise.
`default_nettype none
module pcdt_divider (
  input  wire logic                            core_clk,
  input  wire logic                            sys_rst,
  input  wire logic                            src_edge,
  input  wire logic                            enable,
  input  wire logic [pcdt_pkg::PCDT_RATIO_W-1:0] ratio,
  input  wire logic                            halt,
  input  wire logic                            restart,
  output logic                                 clk_out,
  output logic                                 edge_out
);
  logic [pcdt_pkg::PCDT_RATIO_W-1:0] cnt_ff;
  logic                              out_ff;
  logic [pcdt_pkg::PCDT_RATIO_W-1:0] ratio_eff;
  logic                              terminal;
  logic                              frozen;

  assign ratio_eff = (ratio == 5'h00) ? 5'h01 : ratio;
  assign terminal  = cnt_ff >= (ratio_eff - 5'h01);
  assign frozen    = halt & ~out_ff;
  // Toggling every ratio edges of a two-edge source keeps 50% duty.
  assign edge_out  = enable & src_edge & terminal & ~frozen & ~restart;
  assign clk_out   = out_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_ff <= '0;
      out_ff <= 1'b0;
    end else if (!enable) begin
      cnt_ff <= '0;
      out_ff <= 1'b0;
    end else if (restart) begin
      cnt_ff <= '0;
      out_ff <= 1'b1;
    end else if (frozen) begin
      cnt_ff <= '0;
    end else if (src_edge) begin
      if (terminal) begin
        cnt_ff <= '0;
        out_ff <= ~out_ff;
      end else begin
        cnt_ff <= cnt_ff + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* core/pcdt_tree.sv */
// Purpose: Two clock controllers (nine and five domains) fed by one reference.
// Assumes: ref_clk_pin is far slower than core_clk; controls are core_clk.
// Notes:   The loop is a digital rate multiplier; 2*M must stay below the
//          pre-divided half period in core_clk cycles.
`default_nettype none
module pcdt_tree (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        ref_clk_pin,
  input  wire logic        prim_multiplied_mode_select,
  input  wire logic [4:0]  prim_pre_divider,
  input  wire logic        prim_pre_divider_enable,
  input  wire logic [7:0]  prim_loop_multiplier,
  input  wire logic [4:0]  prim_post_loop_divider,
  input  wire logic        prim_post_divider_enable,
  input  wire logic [4:0]  prim_bypass_clock_divider,
  input  wire logic        prim_bypass_divider_enable,
  input  wire logic [9:1][4:0] prim_domain_divider_n,
  input  wire logic [9:1]  prim_domain_divider_enable,
  input  wire logic [9:1]  prim_output_align_select,
  input  wire logic        prim_divider_update_trigger,
  input  wire logic        sec_multiplied_mode_select,
  input  wire logic [4:0]  sec_pre_divider,
  input  wire logic        sec_pre_divider_enable,
  input  wire logic [7:0]  sec_loop_multiplier,
  input  wire logic [4:0]  sec_post_loop_divider,
  input  wire logic        sec_post_divider_enable,
  input  wire logic [4:0]  sec_bypass_clock_divider,
  input  wire logic        sec_bypass_divider_enable,
  input  wire logic [5:1][4:0] sec_domain_divider_n,
  input  wire logic [5:1]  sec_domain_divider_enable,
  input  wire logic [5:1]  sec_output_align_select,
  input  wire logic        sec_divider_update_trigger,
  output logic [9:1]       prim_domain_clock_n,
  output logic             prim_bypass_domain_clock,
  output logic             prim_divider_update_busy,
  output logic [5:1]       sec_domain_clock_n,
  output logic             sec_bypass_domain_clock,
  output logic             sec_divider_update_busy,
  output logic             auxiliary_reference_clock
);
  logic ref_sync1_ff;
  logic ref_sync2_ff;
  logic ref_prev_ff;
  logic ref_edge;
  logic [2:0] ref_fill_ff;

  logic [1:0]           c_mode_in;
  logic [1:0][4:0]      c_pre_ratio;
  logic [1:0]           c_pre_en;
  logic [1:0][7:0]      c_mult;
  logic [1:0][4:0]      c_post_ratio;
  logic [1:0]           c_post_en;
  logic [1:0][4:0]      c_bp_ratio;
  logic [1:0]           c_bp_en;
  logic [1:0][9:1][4:0] c_dom_ratio;
  logic [1:0][9:1]      c_dom_en;
  logic [1:0][9:1]      c_align;
  logic [1:0]           c_trig;
  logic [1:0][9:1]      c_dom_clk;
  logic [1:0]           c_bp_clk;
  logic [1:0]           c_busy;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ref_sync1_ff <= 1'b0;
      ref_sync2_ff <= 1'b0;
      ref_prev_ff  <= 1'b0;
      ref_fill_ff  <= 3'h0;
    end else begin
      ref_sync1_ff <= ref_clk_pin;
      ref_sync2_ff <= ref_sync1_ff;
      ref_prev_ff  <= ref_sync2_ff;
      ref_fill_ff  <= {ref_fill_ff[1:0], 1'b1};
    end
  end

  // Edges count only once the chain holds real pin samples, so a pin that
  // is high at reset release is not taken for an early edge.
  assign ref_edge = (ref_sync2_ff ^ ref_prev_ff) & ref_fill_ff[2];
  assign auxiliary_reference_clock = ref_prev_ff;

  assign c_mode_in    = {sec_multiplied_mode_select,
                         prim_multiplied_mode_select};
  assign c_pre_ratio  = {sec_pre_divider, prim_pre_divider};
  assign c_pre_en     = {sec_pre_divider_enable, prim_pre_divider_enable};
  assign c_mult       = {sec_loop_multiplier, prim_loop_multiplier};
  assign c_post_ratio = {sec_post_loop_divider, prim_post_loop_divider};
  assign c_post_en    = {sec_post_divider_enable, prim_post_divider_enable};
  assign c_bp_ratio   = {sec_bypass_clock_divider, prim_bypass_clock_divider};
  assign c_bp_en      = {sec_bypass_divider_enable,
                         prim_bypass_divider_enable};
  assign c_trig       = {sec_divider_update_trigger,
                         prim_divider_update_trigger};
  assign c_dom_ratio  = {20'h00000, sec_domain_divider_n,
                         prim_domain_divider_n};
  assign c_dom_en     = {4'h0, sec_domain_divider_enable,
                         prim_domain_divider_enable};
  assign c_align      = {4'h0, sec_output_align_select,
                         prim_output_align_select};

  assign prim_domain_clock_n      = c_dom_clk[0];
  assign sec_domain_clock_n       = c_dom_clk[1][5:1];
  assign prim_bypass_domain_clock = c_bp_clk[0];
  assign sec_bypass_domain_clock  = c_bp_clk[1];
  assign prim_divider_update_busy = c_busy[0];
  assign sec_divider_update_busy  = c_busy[1];

  for (genvar c = 0; c < 2; c++) begin : g_ctrl
    logic                  mode_ff;
    logic                  pre_edge;
    logic                  post_edge;
    logic                  loop_edge;
    logic                  src_edge;
    logic [15:0]           per_cnt_ff;
    logic [15:0]           period_ff;
    logic [16:0]           acc_ff;
    logic [16:0]           acc_sum;
    logic [16:0]           period_ext;
    logic                  loop_tick;
    logic [9:1][4:0]       act_ratio_ff;
    logic [9:1]            halt_mask;
    logic                  all_low;
    logic                  go_restart;
    pcdt_pkg::pcdt_go_e    go_state_ff;
    pcdt_pkg::pcdt_go_e    nxt_go_state;
    logic                  busy_ff;

    // The mode only changes on a reference edge, so the source mux swaps
    // between event streams at an edge boundary and never splits a phase.
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        mode_ff <= pcdt_pkg::PCDT_MODE_RST;
      end else if (ref_edge) begin
        mode_ff <= c_mode_in[c];
      end
    end

    pcdt_divider u_pre (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .src_edge (ref_edge),
      .enable   (mode_ff & c_pre_en[c]),
      .ratio    (c_pre_ratio[c]),
      .halt     (1'b0),
      .restart  (1'b0),
      .clk_out  (),
      .edge_out (pre_edge)
    );

    // The loop measures the pre-divided half period and emits 2*M edges
    // per half period by a running accumulator.
    assign acc_sum    = acc_ff + {8'h00, c_mult[c], 1'b0};
    assign period_ext = {1'b0, period_ff};
    assign loop_tick  = mode_ff & (period_ff != 16'h0000)
                        & (acc_sum >= period_ext);

    always_ff @(posedge core_clk) begin
      if (sys_rst || !mode_ff) begin
        per_cnt_ff <= '0;
        period_ff  <= '0;
        acc_ff     <= '0;
      end else begin
        if (pre_edge) begin
          per_cnt_ff <= '0;
          period_ff  <= per_cnt_ff + 16'h0001;
        end else if (per_cnt_ff != pcdt_pkg::PCDT_PERIOD_MAX) begin
          per_cnt_ff <= per_cnt_ff + 16'h0001;
        end
        if (period_ff == 16'h0000) begin
          acc_ff <= '0;
        end else if (loop_tick) begin
          acc_ff <= acc_sum - period_ext;
        end else begin
          acc_ff <= acc_sum;
        end
      end
    end

    assign loop_edge = loop_tick;

    pcdt_divider u_post (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .src_edge (loop_edge),
      .enable   (mode_ff & c_post_en[c]),
      .ratio    (c_post_ratio[c]),
      .halt     (1'b0),
      .restart  (1'b0),
      .clk_out  (),
      .edge_out (post_edge)
    );

    assign src_edge = mode_ff ? post_edge : ref_edge;

    pcdt_divider u_bypass (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .src_edge (ref_edge),
      .enable   (c_bp_en[c]),
      .ratio    (c_bp_ratio[c]),
      .halt     (1'b0),
      .restart  (1'b0),
      .clk_out  (c_bp_clk[c]),
      .edge_out ()
    );

    // Divider-update sequencing: aligned, enabled outputs freeze low; once
    // all are low the new ratios load and all rise on one source edge.
    assign halt_mask  = (go_state_ff == pcdt_pkg::PCDT_GO_HALT)
                        ? c_align[c] : 9'h000;
    assign all_low    = ((halt_mask & c_dom_en[c] & c_dom_clk[c])
                         == 9'h000);
    assign go_restart = (go_state_ff == pcdt_pkg::PCDT_GO_HALT)
                        & all_low & src_edge;

    always_comb begin
      nxt_go_state = go_state_ff;
      case (go_state_ff)
        pcdt_pkg::PCDT_GO_IDLE: begin
          if (c_trig[c]) begin
            nxt_go_state = pcdt_pkg::PCDT_GO_HALT;
          end
        end
        pcdt_pkg::PCDT_GO_HALT: begin
          if (go_restart) begin
            nxt_go_state = pcdt_pkg::PCDT_GO_IDLE;
          end
        end
        default: nxt_go_state = pcdt_pkg::PCDT_GO_IDLE;
      endcase
    end

    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        go_state_ff <= pcdt_pkg::PCDT_GO_IDLE;
        busy_ff     <= 1'b0;
      end else begin
        go_state_ff <= nxt_go_state;
        busy_ff     <= (nxt_go_state == pcdt_pkg::PCDT_GO_HALT);
      end
    end

    assign c_busy[c] = busy_ff;

    for (genvar d = 1; d <= 9; d++) begin : g_dom
      if (c == 0 || d <= 5) begin : g_on
        always_ff @(posedge core_clk) begin
          if (sys_rst) begin
            act_ratio_ff[d] <= pcdt_pkg::PCDT_RATIO_RST;
          end else if (go_restart && c_align[c][d]) begin
            act_ratio_ff[d] <= c_dom_ratio[c][d];
          end
        end

        pcdt_divider u_dom (
          .core_clk (core_clk),
          .sys_rst  (sys_rst),
          .src_edge (src_edge),
          .enable   (c_dom_en[c][d]),
          .ratio    (act_ratio_ff[d]),
          .halt     (halt_mask[d]),
          .restart  (go_restart & c_align[c][d]),
          .clk_out  (c_dom_clk[c][d]),
          .edge_out ()
        );
      end else begin : g_off
        assign act_ratio_ff[d]    = pcdt_pkg::PCDT_RATIO_RST;
        assign c_dom_clk[c][d]    = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/pcdt_tree_checker.sv */
// Purpose: Port-level assertions for the clock divider tree.
// Assumes: The reference half period spans several core_clk cycles.
// Notes:   Halt and restart are watched on the primary controller.
`default_nettype none
module pcdt_tree_checker (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       ref_clk_pin,
  input wire logic [9:1] prim_domain_divider_enable,
  input wire logic [9:1] prim_output_align_select,
  input wire logic       prim_divider_update_trigger,
  input wire logic       prim_bypass_divider_enable,
  input wire logic [5:1] sec_domain_divider_enable,
  input wire logic       sec_divider_update_trigger,
  input wire logic [9:1] prim_domain_clock_n,
  input wire logic [5:1] sec_domain_clock_n,
  input wire logic       prim_bypass_domain_clock,
  input wire logic       prim_divider_update_busy,
  input wire logic       sec_divider_update_busy,
  input wire logic       auxiliary_reference_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_prim_gate_low: assert property (
    (prim_domain_clock_n & ~$past(prim_domain_divider_enable)) == 9'h000)
    else $error("disabled primary domain clock is high");
  chk_sec_gate_low: assert property (
    (sec_domain_clock_n & ~$past(sec_domain_divider_enable)) == 5'h00)
    else $error("disabled secondary domain clock is high");
  chk_bypass_gate_low: assert property (
    !$past(prim_bypass_divider_enable) |-> !prim_bypass_domain_clock)
    else $error("disabled bypass clock is high");
  chk_prim_busy_start: assert property (
    prim_divider_update_trigger && !prim_divider_update_busy
    |=> prim_divider_update_busy)
    else $error("primary busy did not rise after trigger");
  chk_sec_busy_start: assert property (
    sec_divider_update_trigger && !sec_divider_update_busy
    |=> sec_divider_update_busy)
    else $error("secondary busy did not rise after trigger");
  chk_prim_busy_bound: assert property (
    $rose(prim_divider_update_busy) |-> ##[1:1000] !prim_divider_update_busy)
    else $error("primary update never completed");
  chk_prim_halt_hold: assert property (
    prim_divider_update_busy && $past(prim_divider_update_busy)
    |-> (prim_domain_clock_n & ~$past(prim_domain_clock_n)
         & prim_output_align_select) == 9'h000)
    else $error("aligned clock rose during update");
  chk_prim_restart_high: assert property (
    $fell(prim_divider_update_busy)
    |-> (prim_domain_clock_n & prim_output_align_select
         & prim_domain_divider_enable)
        == (prim_output_align_select & prim_domain_divider_enable))
    else $error("aligned clocks did not restart together");
  chk_aux_ref_delay: assert property (
    !$past(sys_rst, 1) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
    |-> auxiliary_reference_clock == $past(ref_clk_pin, 3))
    else $error("auxiliary clock does not follow reference");
  chk_bypass_no_runt: assert property (
    $rose(prim_bypass_domain_clock) |=> (prim_bypass_domain_clock
    || !$past(prim_bypass_divider_enable)) [*3])
    else $error("runt pulse on bypass clock");
endmodule
`default_nettype wire

/* verification/pcdt_ref_osc.sv */
// Purpose: Free-running reference oscillator for the divider tree.
// Assumes: Half period is a whole number of 4 ns core cycles.
// Notes:   A fixed offset keeps its edges off the core_clk edges.
`default_nettype none
module pcdt_ref_osc #(
  parameter int HALF_CYC = 12
) (
  output var logic ref_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ref_clk = 1'b0;
    #1.3;
    forever #(HALF_CYC * 4) ref_clk = ~ref_clk;
  end
endmodule
`default_nettype wire

/* verification/pcdt_tree_tb.sv */
// Purpose: Self-checking bench for the clock divider tree.
// Assumes: Reference half period is H core cycles, phase-locked.
// Notes:   Active ratios are modelled per output to predict half periods.
`default_nettype none
module pcdt_tree_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int H = 12;
  logic             core_clk, sys_rst, ref_clk, mode, trig;
  logic [13:0][4:0] rat;
  logic [15:0]      en;
  logic [13:0]      aln;
  logic [4:0]       pre, post, bpr;
  logic [7:0]       mul;
  logic [9:1]       pclk;
  logic [5:1]       sclk;
  logic             pbp, sbp, pbusy, sbusy, aux;
  logic [31:0]      seed = 32'h8E3B7591;
  int               act[14];
  int               miscompares = 0, compares = 0, cycles = 0;
  wire  [15:0]      obs = {sbp, pbp, sclk, pclk};
  pcdt_ref_osc #(.HALF_CYC(H)) i_osc (.ref_clk(ref_clk));
  pcdt_tree i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .ref_clk_pin(ref_clk),
    .prim_multiplied_mode_select(mode), .prim_pre_divider(pre),
    .prim_pre_divider_enable(1'b1), .prim_loop_multiplier(mul),
    .prim_post_loop_divider(post), .prim_post_divider_enable(1'b1),
    .prim_bypass_clock_divider(bpr), .prim_bypass_divider_enable(en[14]),
    .prim_domain_divider_n(rat[8:0]), .prim_domain_divider_enable(en[8:0]),
    .prim_output_align_select(aln[8:0]), .prim_divider_update_trigger(trig),
    .sec_multiplied_mode_select(mode), .sec_pre_divider(pre),
    .sec_pre_divider_enable(1'b1), .sec_loop_multiplier(mul),
    .sec_post_loop_divider(post), .sec_post_divider_enable(1'b1),
    .sec_bypass_clock_divider(bpr), .sec_bypass_divider_enable(en[15]),
    .sec_domain_divider_n(rat[13:9]), .sec_domain_divider_enable(en[13:9]),
    .sec_output_align_select(aln[13:9]), .sec_divider_update_trigger(trig),
    .prim_domain_clock_n(pclk), .prim_bypass_domain_clock(pbp),
    .prim_divider_update_busy(pbusy), .sec_domain_clock_n(sclk),
    .sec_bypass_domain_clock(sbp), .sec_divider_update_busy(sbusy),
    .auxiliary_reference_clock(aux));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_half(input int i);
    if (i > 13) return int'(bpr) * H;
    if (mode) return act[i] * pre * H * post / (2 * mul);
    return act[i] * H;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic do_reset();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (act[k]) act[k] = 1;
  endtask
  // Waits for a rising edge, then counts the high and low phases.
  task automatic meas(input int i, output int hi, output int lo);
    int n = 0;
    hi = 0;
    lo = 0;
    while (obs[i] !== 1'b0 && n < 2000) begin @(negedge core_clk); n++; end
    while (obs[i] !== 1'b1 && n < 2000) begin @(negedge core_clk); n++; end
    while (obs[i] === 1'b1 && n < 2000) begin @(negedge core_clk); hi++; end
    while (obs[i] === 1'b0 && n < 2000) begin @(negedge core_clk); lo++; end
  endtask
  task automatic check_all(input string name);
    int hi, lo;
    for (int i = 0; i < 16; i++) begin
      meas(i, hi, lo);
      chk(hi, exp_half(i));
      chk(lo, hi);
    end
    $display("test %0s done", name);
  endtask
  task automatic update();
    logic [13:0][4:0] nr;
    logic [13:0]      al;
    int               n;
    al = 14'(rnd());
    n = 0;
    for (int k = 0; k < 14; k++) begin
      nr[k] = 5'(rnd() % 4 + 1);
      if (al[k]) act[k] = nr[k];
    end
    @(posedge core_clk);
    rat <= nr;
    aln <= al;
    @(posedge core_clk);
    trig <= 1'b1;
    @(posedge core_clk);
    trig <= 1'b0;
    @(negedge core_clk);
    chk(pbusy, 1'b1);
    chk(sbusy, 1'b1);
    while (pbusy !== 1'b0 && n < 3000) begin @(negedge core_clk); n++; end
    chk(pclk & al[8:0], al[8:0]);
    while (sbusy !== 1'b0 && n < 3000) begin @(negedge core_clk); n++; end
    chk(n < 3000, 1'b1);
  endtask
  initial begin
    logic [15:0] acc;
    sys_rst = 1'b1;
    mode = 1'b0;
    trig = 1'b0;
    en = '1;
    aln = '1;
    pre = 5'h02;
    post = 5'h01;
    mul = 8'h02;
    bpr = 5'h02;
    for (int k = 0; k < 14; k++) rat[k] = 5'(rnd() % 4 + 2);
    do_reset();
    check_all("reset");
    repeat (3) begin
      update();
      check_all("update");
    end
    @(posedge core_clk);
    en <= 16'(rnd());
    repeat (2) @(posedge core_clk);
    acc = '0;
    repeat (300) begin @(negedge core_clk); acc |= obs; end
    chk(acc & ~en, 16'h0000);
    chk(acc & en, en);
    $display("test gating done");
    @(posedge core_clk);
    en <= '1;
    mode <= 1'b1;
    repeat (300) @(posedge core_clk);
    check_all("multiplied");
    @(posedge core_clk);
    mode <= 1'b0;
    repeat (8 * H) @(posedge core_clk);
    check_all("bypass");
    do_reset();
    check_all("second reset");
    stop_test();
  end
endmodule
bind pcdt_tree pcdt_tree_checker i_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .ref_clk_pin(ref_clk_pin),
  .prim_domain_divider_enable(prim_domain_divider_enable),
  .prim_output_align_select(prim_output_align_select),
  .prim_divider_update_trigger(prim_divider_update_trigger),
  .prim_bypass_divider_enable(prim_bypass_divider_enable),
  .sec_domain_divider_enable(sec_domain_divider_enable),
  .sec_divider_update_trigger(sec_divider_update_trigger),
  .prim_domain_clock_n(prim_domain_clock_n),
  .sec_domain_clock_n(sec_domain_clock_n),
  .prim_bypass_domain_clock(prim_bypass_domain_clock),
  .prim_divider_update_busy(prim_divider_update_busy),
  .sec_divider_update_busy(sec_divider_update_busy),
  .auxiliary_reference_clock(auxiliary_reference_clock));
`default_nettype wire
